//--- cpi_pkg.sv
// Constants, state encodings and carrier types for the cascaded priority interrupt controller
package cpi_pkg;

  // ----------------------------------------------------------------
  // Port addresses and widths
  // ----------------------------------------------------------------
  localparam int         CPI_LEVELS     = 8;
  localparam logic [7:0] CPI_PORT_CMD   = 8'hE0;  // Init word one, service done, status select
  localparam logic [7:0] CPI_PORT_DATA  = 8'hE2;  // Init words two..six, mask
  localparam logic [7:0] CPI_ZERO8      = 8'h00;
  localparam logic [7:0] CPI_ONES8      = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int         CPI_I1_MARK    = 4;      // Marks init word one on the command port
  localparam int         CPI_I1_LOCAL   = 5;      // Local-input word follows
  localparam int         CPI_I1_TRIG    = 3;      // Per-input trigger word follows
  localparam int         CPI_I1_GLEVEL  = 2;      // Group level sensing when set
  localparam int         CPI_I1_NOCASC  = 1;      // No cascaded slaves
  localparam int         CPI_MODE_SFN   = 4;      // Special fully nested select
  localparam int         CPI_STAT_ISR   = 0;      // Status select: in-service when set
  localparam logic [2:0] CPI_OP_DONE    = 3'h3;   // Bits 7-5 of a specific service-done command
  localparam logic [1:0] CPI_SEL_DONE   = 2'h0;   // Bits 4-3 selecting the service-done form
  localparam logic [1:0] CPI_SEL_STAT   = 2'h1;   // Bits 4-3 selecting status select
  localparam logic [3:0] CPI_NONE       = 4'h8;   // Priority search found nothing
  localparam logic [2:0] CPI_SPUR_LVL   = 3'h7;   // Level reported on an acknowledge with nothing due

  // ----------------------------------------------------------------
  // Initialization sequencer, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    CPI_RUN        = 6'h01,
    CPI_WAIT_BASE  = 6'h02,
    CPI_WAIT_MAP   = 6'h04,
    CPI_WAIT_MODE  = 6'h08,
    CPI_WAIT_TRIG  = 6'h10,
    CPI_WAIT_LOCAL = 6'h20
  } cpi_init_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpi_bus_t;

  typedef struct packed {
    logic       valid;       // One-cycle acknowledge answer
    logic       from_slave;  // Vector left to the cascaded slave
    logic [2:0] level;       // Level acknowledged, also the cascade address
    logic [7:0] vector;      // Vector byte when the master drives it
  } cpi_ack_t;

  typedef struct packed {
    cpi_init_t  init_st;
    logic       ready;
    logic [4:0] vec_base;
    logic [7:0] slave_map;
    logic       nest_special;
    logic       want_trig;
    logic       group_level;
    logic       want_local;
    logic       cascade;
    logic [7:0] trig_sel;
    logic [7:0] local_sel;
    logic [7:0] mask_bits;
    logic [7:0] pend;
    logic [7:0] in_svc;
    logic       read_isr;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] filt;
    logic [7:0] last_filt;
    logic [7:0] rdata;
    cpi_ack_t   ack;
    logic       local_ack_n;
  } cpi_state_t;

endpackage

//--- cpi_ctrl.sv
// Eight-level cascaded master priority interrupt controller
`timescale 1ns/1ps

module cpi_ctrl (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire cpi_pkg::cpi_bus_t bus,
  output logic [7:0]             io_rdata,
  input  wire logic [7:0]        request_inputs,
  input  wire logic              inta,
  output logic                   int_out,
  output cpi_pkg::cpi_ack_t      ack,
  output logic                   local_ack_n
);
  import cpi_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest set index wins, since level 0 has the highest priority
  function automatic logic [3:0] cpi_first(input logic [7:0] v);
    cpi_first = CPI_NONE;
    for (int i = CPI_LEVELS - 1; i >= 0; i--)
      if (v[i])
        cpi_first = 4'(i);
  endfunction

  cpi_state_t s;
  cpi_state_t next_s;
  logic [7:0] level_mode;
  logic [7:0] allow;
  logic [3:0] hi_svc;
  logic [3:0] grant;
  logic [2:0] grant_lvl;
  logic       wr_cmd;
  logic       wr_data;

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Sensing per input, group setting unless a trigger word was asked for
  assign level_mode = s.want_trig ? s.trig_sel : {CPI_LEVELS{s.group_level}};
  assign hi_svc     = cpi_first(s.in_svc);
  assign wr_cmd     = bus.wr && (bus.addr == CPI_PORT_CMD);
  assign wr_data    = bus.wr && (bus.addr == CPI_PORT_DATA);

  // A level may interrupt only if it outranks every level in service, or, under special nesting, is a slave level equal to the highest one
  always_comb
  begin
    for (int i = 0; i < CPI_LEVELS; i++)
      allow[i] = s.pend[i] && !s.mask_bits[i]
                 && ((4'(i) < hi_svc)
                     || (s.nest_special && s.slave_map[i] && 4'(i) == hi_svc));
  end

  assign grant     = cpi_first(allow);
  assign grant_lvl = grant[2:0];
  assign int_out   = s.ready && (grant != CPI_NONE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s             = s;
    next_s.ack.valid   = 1'b0;
    next_s.local_ack_n = 1'b1;

    // Three-stage synchroniser; a change counts once stages two and three agree
    next_s.sync1     = request_inputs;
    next_s.sync2     = s.sync1;
    next_s.sync3     = s.sync2;
    next_s.last_filt = s.filt;
    for (int i = 0; i < CPI_LEVELS; i++)
      if (s.sync2[i] == s.sync3[i])
        next_s.filt[i] = s.sync2[i];

    // Request latch: level inputs follow, edge inputs catch a rise and hold while high
    for (int i = 0; i < CPI_LEVELS; i++)
      if (level_mode[i])
        next_s.pend[i] = s.filt[i];
      else if (s.filt[i] && !s.last_filt[i])
        next_s.pend[i] = 1'b1;
      else if (!s.filt[i])
        next_s.pend[i] = 1'b0;

    // Register reads answer one cycle later and hold until the next read
    if (bus.rd)
    begin
      if (bus.addr == CPI_PORT_CMD)
        next_s.rdata = s.read_isr ? s.in_svc : s.pend;
      else if (bus.addr == CPI_PORT_DATA)
        next_s.rdata = s.mask_bits;
      else
        next_s.rdata = CPI_ZERO8;
    end

    // Command port
    if (wr_cmd && bus.wdata[CPI_I1_MARK])
    begin
      // Restart: edge detectors rearmed by pretending every input was high
      next_s.init_st      = CPI_WAIT_BASE;
      next_s.ready        = 1'b0;
      next_s.mask_bits    = CPI_ZERO8;
      next_s.read_isr     = 1'b0;
      next_s.last_filt    = CPI_ONES8;
      next_s.pend         = CPI_ZERO8;
      next_s.want_local   = bus.wdata[CPI_I1_LOCAL];
      next_s.want_trig    = bus.wdata[CPI_I1_TRIG];
      next_s.group_level  = bus.wdata[CPI_I1_GLEVEL];
      next_s.cascade      = !bus.wdata[CPI_I1_NOCASC];
      next_s.slave_map    = CPI_ZERO8;
      next_s.trig_sel     = CPI_ZERO8;
      next_s.local_sel    = CPI_ZERO8;
      next_s.nest_special = 1'b0;
    end
    else if (wr_cmd && bus.wdata[4:3] == CPI_SEL_DONE)
    begin
      // Only the specific form is honoured; others are ignored
      if (bus.wdata[7:5] == CPI_OP_DONE)
        next_s.in_svc[bus.wdata[2:0]] = 1'b0;
    end
    else if (wr_cmd && bus.wdata[4:3] == CPI_SEL_STAT)
      next_s.read_isr = bus.wdata[CPI_STAT_ISR];

    // Data port: initialization sequence, then the mask
    if (wr_data)
    begin
      case (s.init_st)
        CPI_WAIT_BASE:
        begin
          next_s.vec_base = bus.wdata[7:3];
          next_s.init_st  = s.cascade ? CPI_WAIT_MAP : CPI_WAIT_MODE;
        end
        CPI_WAIT_MAP:
        begin
          next_s.slave_map = bus.wdata;
          next_s.init_st   = CPI_WAIT_MODE;
        end
        CPI_WAIT_MODE:
        begin
          next_s.nest_special = bus.wdata[CPI_MODE_SFN];
          if (s.want_trig)
            next_s.init_st = CPI_WAIT_TRIG;
          else if (s.want_local)
            next_s.init_st = CPI_WAIT_LOCAL;
          else
          begin
            next_s.init_st = CPI_RUN;
            next_s.ready   = 1'b1;
          end
        end
        CPI_WAIT_TRIG:
        begin
          next_s.trig_sel = bus.wdata;
          if (s.want_local)
            next_s.init_st = CPI_WAIT_LOCAL;
          else
          begin
            next_s.init_st = CPI_RUN;
            next_s.ready   = 1'b1;
          end
        end
        CPI_WAIT_LOCAL:
        begin
          next_s.local_sel = bus.wdata;
          next_s.init_st   = CPI_RUN;
          next_s.ready     = 1'b1;
        end
        CPI_RUN:
          next_s.mask_bits = bus.wdata;
        default:
          next_s.init_st = CPI_RUN;
      endcase
    end

    // Acknowledge comes last so an in-service set beats a same-cycle clear
    if (inta)
    begin
      next_s.ack.valid = 1'b1;
      if (int_out)
      begin
        next_s.in_svc[grant_lvl] = 1'b1;
        next_s.pend[grant_lvl]   = 1'b0;
        next_s.ack.level         = grant_lvl;
        next_s.ack.from_slave    = s.cascade && s.slave_map[grant_lvl];
        next_s.ack.vector        = {s.vec_base, grant_lvl};
        next_s.local_ack_n       = !s.local_sel[grant_lvl];
      end
      else
      begin
        // Nothing due: answer with level 7, the lowest priority, nothing goes in service
        next_s.ack.level      = CPI_SPUR_LVL;
        next_s.ack.from_slave = 1'b0;
        next_s.ack.vector     = {s.vec_base, CPI_SPUR_LVL};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s             <= '0;
      s.init_st     <= CPI_RUN;
      s.last_filt   <= CPI_ONES8;
      s.local_ack_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign io_rdata    = s.rdata;
  assign ack         = s.ack;
  assign local_ack_n = s.local_ack_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  init_restart_a: assert property (
    wr_cmd && bus.wdata[CPI_I1_MARK]
    |=> s.init_st == CPI_WAIT_BASE && s.mask_bits == CPI_ZERO8 && !s.read_isr && !int_out)
    else $error("init word one did not restart");

  init_order_a: assert property (
    s.init_st == CPI_WAIT_BASE && wr_data && !wr_cmd
    |=> s.init_st == ($past(s.cascade) ? CPI_WAIT_MAP : CPI_WAIT_MODE) ##0 s.vec_base == $past(bus.wdata[7:3]))
    else $error("init sequence order wrong");

  master_vector_a: assert property (
    ack.valid && !ack.from_slave |-> ack.vector == {s.vec_base, ack.level})
    else $error("vector byte malformed");

  // Back-to-back acknowledges are legal, so a low output is only tied to its own answer cycle
  local_ack_a: assert property (
    !local_ack_n |-> ack.valid && s.local_sel[ack.level])
    else $error("local acknowledge wrong");

  mask_load_a: assert property (
    s.init_st == CPI_RUN && wr_data |=> s.mask_bits == $past(bus.wdata))
    else $error("mask not loaded");

  done_clear_a: assert property (
    wr_cmd && bus.wdata[7:3] == {CPI_OP_DONE, CPI_SEL_DONE} && !inta
    |=> !s.in_svc[$past(bus.wdata[2:0])])
    else $error("service done did not clear");

  ack_service_a: assert property (
    inta && int_out |=> ack.valid && s.in_svc[ack.level] && ack.level == $past(grant_lvl))
    else $error("acknowledge did not set in-service");

  nest_block_a: assert property (
    int_out && hi_svc != CPI_NONE
    |-> grant < hi_svc || (s.nest_special && s.slave_map[grant_lvl] && grant == hi_svc))
    else $error("blocked level interrupted");

  status_read_a: assert property (
    bus.rd && bus.addr == CPI_PORT_CMD |=> io_rdata == $past(s.read_isr ? s.in_svc : s.pend))
    else $error("status read wrong");

  mask_read_a: assert property (
    bus.rd && bus.addr == CPI_PORT_DATA |=> io_rdata == $past(s.mask_bits))
    else $error("mask read wrong");

  slave_vector_a: assert property (
    ack.valid && ack.from_slave |-> s.slave_map[ack.level] && s.cascade)
    else $error("slave vector on wrong level");

  init_opts_a: assert property (
    wr_cmd && bus.wdata[CPI_I1_MARK]
    |=> s.want_local == $past(bus.wdata[CPI_I1_LOCAL]) && s.want_trig == $past(bus.wdata[CPI_I1_TRIG])
        && s.group_level == $past(bus.wdata[CPI_I1_GLEVEL]) && s.cascade == !$past(bus.wdata[CPI_I1_NOCASC]))
    else $error("init word one options not taken");

  init_done_a: assert property (
    s.init_st == CPI_WAIT_MODE && wr_data && !s.want_trig && !s.want_local |=> s.ready && s.init_st == CPI_RUN)
    else $error("init did not finish after mode word");

  slave_map_a: assert property (
    s.init_st == CPI_WAIT_MAP && wr_data |=> s.slave_map == $past(bus.wdata) && s.init_st == CPI_WAIT_MODE)
    else $error("slave map not loaded");

  mode_word_a: assert property (
    s.init_st == CPI_WAIT_MODE && wr_data |=> s.nest_special == $past(bus.wdata[CPI_MODE_SFN]))
    else $error("mode word not taken");

  trig_word_a: assert property (
    s.init_st == CPI_WAIT_TRIG && wr_data |=> s.trig_sel == $past(bus.wdata) && level_mode == s.trig_sel)
    else $error("trigger word not taken");

  not_ready_a: assert property (
    !s.ready |-> !int_out)
    else $error("interrupt raised before init finished");

  local_low_a: assert property (
    inta && int_out && s.local_sel[grant_lvl] |=> !local_ack_n)
    else $error("local acknowledge not driven");

  slave_lock_a: assert property (
    int_out && !s.nest_special |-> !s.in_svc[grant_lvl])
    else $error("in-service level re-admitted");

  int_drop_a: assert property (
    inta && int_out |=> !s.pend[$past(grant_lvl)])
    else $error("acknowledged request still pending");

  // An acknowledge with nothing due must leave the in-service register alone
  spur_ack_a: assert property (
    inta && !int_out && !wr_cmd
    |=> ack.valid && ack.level == CPI_SPUR_LVL && local_ack_n && s.in_svc == $past(s.in_svc))
    else $error("spurious acknowledge changed state");

  status_sel_a: assert property (
    wr_cmd && bus.wdata[4:3] == CPI_SEL_STAT |=> s.read_isr == $past(bus.wdata[CPI_STAT_ISR]))
    else $error("status selection not taken");

  cov_ack_c:    cover property (inta && int_out ##1 ack.valid && !ack.from_slave);
  cov_slave_c:  cover property (ack.valid && ack.from_slave);
  cov_nest_c:   cover property (int_out && hi_svc != CPI_NONE && grant == hi_svc);
  cov_done_c:   cover property (wr_cmd && bus.wdata[7:3] == {CPI_OP_DONE, CPI_SEL_DONE});

endmodule // cpi_ctrl

//--- cpi_src_model.sv
// Request sources that sit behind the request lines
`timescale 1ns/1ps

module cpi_src_model (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [7:0]        raise,
  input  wire cpi_pkg::cpi_ack_t ack,
  output logic [7:0]             request_inputs
);
  import cpi_pkg::*;
  // ----------------------------------------------------------------
  // Request lines
  // ----------------------------------------------------------------
  // A line stays up until its own level is acknowledged, so edge sensing sees a stable level
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      request_inputs <= 8'h00;
    else if (ack.valid)
      request_inputs <= (request_inputs | raise) & ~(8'h01 << ack.level);
    else
      request_inputs <= request_inputs | raise;
  end
endmodule // cpi_src_model

//--- cpi_ctrl_tb.sv
// Self-checking testbench for the cascaded priority interrupt controller
`timescale 1ns/1ps

module cpi_ctrl_tb;
  import cpi_pkg::*;

  logic       clk_sys;
  logic       rst;
  cpi_bus_t   bus;
  logic [7:0] io_rdata;
  logic [7:0] request_inputs;
  logic [7:0] raise;
  logic       inta;
  logic       int_out;
  cpi_ack_t   ack;
  logic       local_ack_n;
  int         n_errors;
  int         samples_checked;
  int         cycles;

  cpi_ctrl dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .io_rdata(io_rdata),
    .request_inputs(request_inputs), .inta(inta), .int_out(int_out), .ack(ack), .local_ack_n(local_ack_n));

  cpi_src_model src (.clk_sys(clk_sys), .rst(rst), .raise(raise), .ack(ack), .request_inputs(request_inputs));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // The whole run needs well under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= {1'b0, 1'b0, 8'h00, 8'h00};
  endtask

  // Read data is registered, so it is taken just after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus <= {1'b0, 1'b0, 8'h00, 8'h00};
    #1;
    chk(io_rdata, exp);
  endtask

  task automatic rq(input int lvl);
    @(posedge clk_sys);
    raise <= 8'h01 << lvl;
    @(posedge clk_sys);
    raise <= 8'h00;
  endtask

  task automatic wait_int();
    int i;
    i = 0;
    while (int_out !== 1'b1 && i < 20)
    begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    chk({7'h00, int_out}, 8'h01);
  endtask

  task automatic quiet();
    repeat (10) @(posedge clk_sys);
    #1;
    chk({7'h00, int_out}, 8'h00);
  endtask

  // One acknowledge pulse; the answer is looked at in the single cycle it stands
  task automatic do_ack(input logic [2:0] lvl, input logic [7:0] vec, input logic slv, input logic lan);
    @(posedge clk_sys);
    inta <= 1'b1;
    @(posedge clk_sys);
    inta <= 1'b0;
    #1;
    chk({7'h00, ack.valid}, 8'h01);
    chk({5'h00, ack.level}, {5'h00, lvl});
    chk({7'h00, ack.from_slave}, {7'h00, slv});
    chk({7'h00, local_ack_n}, {7'h00, lan});
    if (!slv)
      chk(ack.vector, vec);
    repeat (6) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    bus = {1'b0, 1'b0, 8'h00, 8'h00};
    raise = 8'h00;
    inta = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'hE2, 8'h5A);
    // Cascaded, per-input trigger word, local word; ordinary nesting
    wr(CPI_PORT_CMD, 8'h38);
    wr(CPI_PORT_DATA, 8'h20);
    wr(CPI_PORT_DATA, 8'h58);
    wr(CPI_PORT_DATA, 8'h00);
    wr(CPI_PORT_DATA, 8'h00);
    wr(CPI_PORT_DATA, 8'hFF);
    rd(CPI_PORT_DATA, 8'h00);
    rd(CPI_PORT_CMD, 8'h00);
    // Masked level stays silent, then an unmasked one is served
    wr(CPI_PORT_DATA, 8'h04);
    rd(CPI_PORT_DATA, 8'h04);
    rq(2);
    quiet();
    rq(5);
    wait_int();
    do_ack(3'd5, 8'h25, 1'b0, 1'b0);
    chk({7'h00, int_out}, 8'h00);
    wr(CPI_PORT_DATA, 8'h00);
    wait_int();
    do_ack(3'd2, 8'h22, 1'b0, 1'b0);
    wr(CPI_PORT_CMD, 8'h0B);
    rd(CPI_PORT_CMD, 8'h24);
    rd(CPI_PORT_CMD, 8'h24);
    rq(7);
    quiet();
    wr(CPI_PORT_CMD, 8'h22);
    rd(CPI_PORT_CMD, 8'h24);
    wr(CPI_PORT_CMD, 8'h62);
    rd(CPI_PORT_CMD, 8'h20);
    wr(CPI_PORT_CMD, 8'h65);
    wait_int();
    do_ack(3'd7, 8'h27, 1'b0, 1'b0);
    wr(CPI_PORT_CMD, 8'h67);
    // Slave level leaves the vector to the slave and is locked out while served
    rq(3);
    wait_int();
    do_ack(3'd3, 8'h23, 1'b1, 1'b0);
    rq(3);
    quiet();
    wr(CPI_PORT_CMD, 8'h0A);
    rd(CPI_PORT_CMD, 8'h08);
    wr(CPI_PORT_CMD, 8'h63);
    wait_int();
    do_ack(3'd3, 8'h23, 1'b1, 1'b0);
    wr(CPI_PORT_CMD, 8'h63);
    // Re-initialize: group edge, no trigger word, special nesting, low levels local only
    wr(CPI_PORT_CMD, 8'h0B);
    wr(CPI_PORT_CMD, 8'h30);
    wr(CPI_PORT_DATA, 8'h40);
    wr(CPI_PORT_DATA, 8'h50);
    wr(CPI_PORT_DATA, 8'h10);
    wr(CPI_PORT_DATA, 8'h0F);
    rq(1);
    wait_int();
    do_ack(3'd1, 8'h41, 1'b0, 1'b0);
    rd(CPI_PORT_CMD, 8'h00);
    wr(CPI_PORT_CMD, 8'h61);
    rq(6);
    wait_int();
    do_ack(3'd6, 8'h46, 1'b1, 1'b1);
    rq(6);
    wait_int();
    do_ack(3'd6, 8'h46, 1'b1, 1'b1);
    // Acknowledge with nothing due answers level 7 and sets nothing in service
    do_ack(3'd7, 8'h47, 1'b0, 1'b1);
    wr(CPI_PORT_CMD, 8'h0B);
    rd(CPI_PORT_CMD, 8'h40);
    // Line 2 goes up before the restart, so only level sensing can still see it
    rq(2);
    wr(CPI_PORT_CMD, 8'h66);
    rd(CPI_PORT_CMD, 8'h00);
    wr(CPI_PORT_CMD, 8'h16);
    wr(CPI_PORT_DATA, 8'h60);
    wr(CPI_PORT_DATA, 8'h00);
    wait_int();
    do_ack(3'd2, 8'h62, 1'b0, 1'b1);
    end_of_test();
  end
endmodule // cpi_ctrl_tb
